// ### event_compare_consts.vh
// Constants for the compare-mode event channels and their two timers.
// Assumes a 40 MHz core clock and a plain address/strobe register port.
//
// Overview of operation
// - On timer match with event time, set, clear, toggle the pin or start conversion.
// - With repeat enabled, the action recurs on every later match.
// - With repeat clear, one action only until the event time is rewritten.
// - Toggle with repeat inverts the pin and raises the channel event each match.
// - Pair bit in channel one or three control puts channels 0/1 or 2/3 on one pin.
// - Paired set and clear times one count apart give a one-count pulse.
// - A channel may invert the pin and clear its timer, restarting a PWM cycle.
// - Finest timer step is 200 ns, so fastest PWM is bounded by it.
// - Timer two on its external clock pin disables channel 0.
// - Timer two on its direction pin disables channel 1.
// - A write to a timer count register loads that timer directly.
// - One service cycle of the period engine takes 15 state times.
// - Control bit 7 picks the reference timer; matches use the reference timer.
// - Control bit 6 clear is capture mode, set is compare mode.
// - Control bits 5:4 pick none, drive low, drive high or invert.
`ifndef EVENT_COMPARE_CONSTS_VH
`define EVENT_COMPARE_CONSTS_VH

`define ADDR_TIMER_ONE_CONTROL 16'h1F98
`define ADDR_TIMER_ONE_COUNT   16'h1F9A
`define ADDR_TIMER_TWO_CONTROL 16'h1F9C
`define ADDR_TIMER_TWO_COUNT   16'h1F9E
`define ADDR_CHAN_CTRL_BASE    16'h1F60
`define ADDR_CHAN_TIME_BASE    16'h1F62
`define CHAN_STRIDE            16'h0004
`define ADDR_MATCH_STATUS      16'h1FA0
`define ADDR_SVC_ENABLE        16'h1FA2
`define ADDR_SVC_PERIOD        16'h1FA4

`define CTL_RESET_TIMER  0
`define CTL_OPPOSITE     1
`define CTL_AD_START     2
`define CTL_REPEAT       3
`define CTL_ACT_LO       4
`define CTL_ACT_HI       5
`define CTL_COMPARE      6
`define CTL_REF_TIMER    7
`define CTL_PAIR_PIN     8

`define TCTL_ENABLE      7
`define TCTL_UP          6
`define TCTL_MODE_HI     5
`define TCTL_MODE_LO     3
`define TCTL_PRE_HI      2

`define ACT_NONE         2'h0
`define ACT_LOW          2'h1
`define ACT_HIGH         2'h2
`define ACT_TOGGLE       2'h3

`define TMODE_QUAD       3'h7
`define TMODE_CASCADE    3'h6
`define PRE_RESERVED     3'h7

`define CTRL_RESET       9'h000
`define TCTL_RESET       8'h00

`define CLK_MHZ          40
`define TICK_NS          200
`define TICK_CYC         ((`TICK_NS * `CLK_MHZ) / 1000)
`define STATE_NS         50
`define SVC_STATES       15
`define SVC_CYC          ((`SVC_STATES * `STATE_NS * `CLK_MHZ) / 1000)

`endif

// ### event_compare_pwm_channels.v
// Four compare-mode event channels on two 16-bit timers, with pin pairing and a period engine.
// Assumes registers are reached by a one-cycle strobe port with read data one cycle later.
`timescale 1ns/100ps
`include "event_compare_consts.vh"

module event_compare_pwm_channels (
    // Clock and reset
    input  wire        core_clk,
    input  wire        srst,
    // Register port
    input  wire [15:0] reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    // Timer pins
    input  wire        timer_one_ext_clock_pin,
    input  wire        timer_one_dir_pin,
    input  wire        timer_two_ext_clock_pin,
    input  wire        timer_two_dir_pin,
    // Channel pins and events
    output reg  [3:0]  chan_pin_out,
    output reg  [3:0]  chan_pin_oe,
    output reg  [3:0]  chan_event,
    output reg         ad_start
);

    reg  [1:0]  clk_s1_reg;
    reg  [1:0]  clk_s2_reg;
    reg  [1:0]  clk_s3_reg;
    reg  [1:0]  dir_s1_reg;
    reg  [1:0]  dir_s2_reg;
    reg  [3:0]  tick_cnt_reg;
    reg         base_tick_reg;
    reg  [7:0]  tctl_reg [0:1];
    reg  [15:0] tcnt_reg [0:1];
    reg  [5:0]  pre_cnt_reg [0:1];
    reg  [1:0]  tupd_reg;
    reg  [8:0]  ctl_reg [0:3];
    reg  [15:0] time_reg [0:3];
    reg  [3:0]  armed_reg;
    reg  [3:0]  status_reg;
    reg  [3:0]  svc_en_reg;
    reg  [15:0] period_reg;
    reg  [3:0]  pend_reg;
    reg  [4:0]  svc_cnt_reg;
    reg  [1:0]  svc_chan_reg;
    reg  [3:0]  pin_next;
    reg  [3:0]  oe_next;
    reg  [1:0]  treset_next;
    reg  [1:0]  pend_pick;
    reg         pend_any;
    reg  [3:0]  pend_next;
    reg  [15:0] rdata_next;
    reg  [2:0]  pin_idx;
    wire [3:0]  hit;
    wire [3:0]  avail;
    wire [3:0]  time_wr;
    wire [1:0]  tcnt_wr;
    wire [1:0]  tctl_wr;
    wire        svc_done;
    wire        pair_one;
    wire        pair_three;
    wire [2:0]  t2_mode;
    integer     i;
    integer     j;

    // Counter reload values, cut to the widths of the counters that they feed.
    localparam integer TICK_LAST = `TICK_CYC - 1;
    localparam integer SVC_LOAD  = `SVC_CYC;

    assign t2_mode    = tctl_reg[1][`TCTL_MODE_HI:`TCTL_MODE_LO];
    assign pair_one   = ctl_reg[1][`CTL_PAIR_PIN];
    assign pair_three = ctl_reg[3][`CTL_PAIR_PIN];
    assign svc_done   = (svc_cnt_reg == 5'h01);
    assign tctl_wr[0] = reg_wr && (reg_addr == `ADDR_TIMER_ONE_CONTROL);
    assign tctl_wr[1] = reg_wr && (reg_addr == `ADDR_TIMER_TWO_CONTROL);
    assign tcnt_wr[0] = reg_wr && (reg_addr == `ADDR_TIMER_ONE_COUNT);
    assign tcnt_wr[1] = reg_wr && (reg_addr == `ADDR_TIMER_TWO_COUNT);

    // Channel 0 shares its pin with the timer two clock, channel 1 with its direction.
    assign avail[0] = !(t2_mode[0] && (t2_mode != `TMODE_QUAD));
    assign avail[1] = !((t2_mode == 3'h2) || (t2_mode == 3'h3) ||
                        (t2_mode == `TMODE_QUAD));
    assign avail[2] = 1'b1;
    assign avail[3] = 1'b1;

    // Pin inputs pass two flip-flops; the third stage only serves edge detection.
    always @(posedge core_clk) begin
        if (srst) begin
            clk_s1_reg <= 2'h0;
            clk_s2_reg <= 2'h0;
            clk_s3_reg <= 2'h0;
            dir_s1_reg <= 2'h0;
            dir_s2_reg <= 2'h0;
        end else begin
            clk_s1_reg <= {timer_two_ext_clock_pin, timer_one_ext_clock_pin};
            clk_s2_reg <= clk_s1_reg;
            clk_s3_reg <= clk_s2_reg;
            dir_s1_reg <= {timer_two_dir_pin, timer_one_dir_pin};
            dir_s2_reg <= dir_s1_reg;
        end
    end

    // Base tick at the finest timer resolution.
    always @(posedge core_clk) begin
        if (srst) begin
            tick_cnt_reg  <= 4'h0;
            base_tick_reg <= 1'b0;
        end else begin
            base_tick_reg <= (tick_cnt_reg == TICK_LAST[3:0]);
            if (tick_cnt_reg == TICK_LAST[3:0]) begin
                tick_cnt_reg <= 4'h0;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 4'h1;
            end
        end
    end

    genvar t;
    generate
        for (t = 0; t < 2; t = t + 1) begin : timer_gen
            wire [2:0] mode;
            wire [2:0] pre;
            wire       pre_hit;
            wire       src;
            wire       up;
            wire       step;
            assign mode    = tctl_reg[t][`TCTL_MODE_HI:`TCTL_MODE_LO];
            assign pre     = tctl_reg[t][`TCTL_PRE_HI:0];
            assign pre_hit = base_tick_reg && (pre != `PRE_RESERVED) &&
                             ((pre_cnt_reg[t] & ((6'h01 << pre) - 6'h01)) ==
                              ((6'h01 << pre) - 6'h01));
            assign src     = (mode == `TMODE_QUAD) || (mode == `TMODE_CASCADE) ? 1'b0 :
                             mode[0] ? (clk_s2_reg[t] ^ clk_s3_reg[t]) : pre_hit;
            assign up      = mode[1] ? dir_s2_reg[t] : tctl_reg[t][`TCTL_UP];
            assign step    = tctl_reg[t][`TCTL_ENABLE] && src;

            always @(posedge core_clk) begin
                if (srst) begin
                    tctl_reg[t]    <= `TCTL_RESET;
                    tcnt_reg[t]    <= 16'h0000;
                    pre_cnt_reg[t] <= 6'h00;
                    tupd_reg[t]    <= 1'b0;
                end else begin
                    if (tctl_wr[t]) begin
                        tctl_reg[t] <= reg_wdata[7:0];
                    end
                    if (base_tick_reg) begin
                        pre_cnt_reg[t] <= pre_cnt_reg[t] + 6'h01;
                    end
                    // A count write or a reset by a match replaces that cycle's step.
                    tupd_reg[t] <= step && !tcnt_wr[t] && !treset_next[t];
                    if (tcnt_wr[t]) begin
                        tcnt_reg[t] <= reg_wdata;
                    end else if (treset_next[t]) begin
                        tcnt_reg[t] <= 16'h0000;
                    end else if (step) begin
                        tcnt_reg[t] <= up ? tcnt_reg[t] + 16'h0001 : tcnt_reg[t] - 16'h0001;
                    end
                end
            end
        end
    endgenerate

    genvar c;
    generate
        for (c = 0; c < 4; c = c + 1) begin : chan_gen
            localparam integer CHAN_OFS = c * `CHAN_STRIDE;
            wire        ref_sel;
            wire [15:0] ref_cnt;
            wire        ref_upd;
            wire        ctl_wr;
            wire [15:0] ctl_addr;
            wire [15:0] time_addr;
            assign ref_sel = ctl_reg[c][`CTL_REF_TIMER];
            assign ref_cnt = ref_sel ? tcnt_reg[1] : tcnt_reg[0];
            assign ref_upd = ref_sel ? tupd_reg[1] : tupd_reg[0];
            assign ctl_addr   = `ADDR_CHAN_CTRL_BASE + CHAN_OFS[15:0];
            assign time_addr  = `ADDR_CHAN_TIME_BASE + CHAN_OFS[15:0];
            assign ctl_wr     = reg_wr && (reg_addr == ctl_addr);
            assign time_wr[c] = reg_wr && (reg_addr == time_addr);
            assign hit[c] = ctl_reg[c][`CTL_COMPARE] && armed_reg[c] && avail[c] &&
                            ref_upd && (ref_cnt == time_reg[c]);

            always @(posedge core_clk) begin
                if (srst) begin
                    ctl_reg[c]   <= `CTRL_RESET;
                    time_reg[c]  <= 16'h0000;
                    armed_reg[c] <= 1'b0;
                end else begin
                    if (ctl_wr) begin
                        ctl_reg[c] <= (c == 1 || c == 3) ? reg_wdata[8:0]
                                                         : {1'b0, reg_wdata[7:0]};
                    end
                    // A time write arms the channel and wins over a period update.
                    if (time_wr[c]) begin
                        time_reg[c]  <= reg_wdata;
                        armed_reg[c] <= 1'b1;
                    end else if (svc_done && (svc_chan_reg == c)) begin
                        time_reg[c]  <= time_reg[c] + period_reg;
                        armed_reg[c] <= 1'b1;
                    end else if (hit[c] && !ctl_reg[c][`CTL_REPEAT]) begin
                        armed_reg[c] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Compare actions on the pins; paired channel 0 or 2 acts on its partner's pin.
    always @* begin
        pin_next    = chan_pin_out;
        treset_next = 2'h0;
        pin_idx     = 3'h0;
        for (i = 0; i < 4; i = i + 1) begin
            pin_idx = i[2:0];
            if ((i == 0 && pair_one) || (i == 2 && pair_three)) begin
                pin_idx = i[2:0] + 3'h1;
            end
            if (hit[i]) begin
                case (ctl_reg[i][`CTL_ACT_HI:`CTL_ACT_LO])
                    `ACT_LOW:    pin_next[pin_idx[1:0]] = 1'b0;
                    `ACT_HIGH:   pin_next[pin_idx[1:0]] = 1'b1;
                    `ACT_TOGGLE: pin_next[pin_idx[1:0]] = ~pin_next[pin_idx[1:0]];
                    default:     pin_next[pin_idx[1:0]] = pin_next[pin_idx[1:0]];
                endcase
                if (ctl_reg[i][`CTL_RESET_TIMER]) begin
                    if (ctl_reg[i][`CTL_REF_TIMER] ^ ctl_reg[i][`CTL_OPPOSITE]) begin
                        treset_next[1] = 1'b1;
                    end else begin
                        treset_next[0] = 1'b1;
                    end
                end
            end
        end
        for (i = 0; i < 4; i = i + 1) begin
            oe_next[i] = ctl_reg[i][`CTL_COMPARE] && avail[i];
        end
        if (pair_one) begin
            oe_next[0] = 1'b0;
            oe_next[1] = oe_next[1] || (ctl_reg[0][`CTL_COMPARE] && avail[0]);
        end
        if (pair_three) begin
            oe_next[2] = 1'b0;
            oe_next[3] = oe_next[3] || ctl_reg[2][`CTL_COMPARE];
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            chan_pin_out <= 4'h0;
            chan_pin_oe  <= 4'h0;
            chan_event   <= 4'h0;
            ad_start     <= 1'b0;
        end else begin
            chan_pin_out <= pin_next;
            chan_pin_oe  <= oe_next;
            chan_event   <= hit;
            ad_start     <= |(hit & {ctl_reg[3][`CTL_AD_START], ctl_reg[2][`CTL_AD_START],
                                     ctl_reg[1][`CTL_AD_START], ctl_reg[0][`CTL_AD_START]});
        end
    end

    // Period engine: one pending channel at a time, lowest index first.
    always @* begin
        pend_next = pend_reg | (hit & svc_en_reg);
        pend_any  = |pend_next;
        pend_pick = pend_next[0] ? 2'h0 : pend_next[1] ? 2'h1 : pend_next[2] ? 2'h2 : 2'h3;
    end

    always @(posedge core_clk) begin
        if (srst) begin
            svc_en_reg   <= 4'h0;
            period_reg   <= 16'h0000;
            pend_reg     <= 4'h0;
            svc_cnt_reg  <= 5'h00;
            svc_chan_reg <= 2'h0;
        end else begin
            if (reg_wr && (reg_addr == `ADDR_SVC_ENABLE)) begin
                svc_en_reg <= reg_wdata[3:0];
            end
            if (reg_wr && (reg_addr == `ADDR_SVC_PERIOD)) begin
                period_reg <= reg_wdata;
            end
            if ((svc_cnt_reg == 5'h00) && pend_any) begin
                svc_cnt_reg  <= SVC_LOAD[4:0];
                svc_chan_reg <= pend_pick;
                pend_reg     <= pend_next & ~(4'h1 << pend_pick);
            end else begin
                pend_reg <= pend_next;
                if (svc_cnt_reg != 5'h00) begin
                    svc_cnt_reg <= svc_cnt_reg - 5'h01;
                end
            end
        end
    end

    // Sticky match status: write one to clear, a new match wins over the clear.
    always @(posedge core_clk) begin
        if (srst) begin
            status_reg <= 4'h0;
        end else if (reg_wr && (reg_addr == `ADDR_MATCH_STATUS)) begin
            status_reg <= (status_reg & ~reg_wdata[3:0]) | hit;
        end else begin
            status_reg <= status_reg | hit;
        end
    end

    always @* begin
        rdata_next = 16'h0000;
        case (reg_addr)
            `ADDR_TIMER_ONE_CONTROL: rdata_next = {8'h00, tctl_reg[0]};
            `ADDR_TIMER_TWO_CONTROL: rdata_next = {8'h00, tctl_reg[1]};
            `ADDR_TIMER_ONE_COUNT:   rdata_next = tcnt_reg[0];
            `ADDR_TIMER_TWO_COUNT:   rdata_next = tcnt_reg[1];
            `ADDR_MATCH_STATUS:      rdata_next = {12'h000, status_reg};
            `ADDR_SVC_ENABLE:        rdata_next = {12'h000, svc_en_reg};
            `ADDR_SVC_PERIOD:        rdata_next = period_reg;
            default: begin
                for (j = 0; j < 4; j = j + 1) begin
                    if (reg_addr == `ADDR_CHAN_CTRL_BASE + j[15:0] * `CHAN_STRIDE) begin
                        rdata_next = {7'h00, ctl_reg[j]};
                    end
                    if (reg_addr == `ADDR_CHAN_TIME_BASE + j[15:0] * `CHAN_STRIDE) begin
                        rdata_next = time_reg[j];
                    end
                end
            end
        endcase
    end

    // Read data stand only in the cycle after the read strobe and are zero otherwise.
    always @(posedge core_clk) begin
        if (srst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule // event_compare_pwm_channels

// ### pwm_load.sv
// External load on the channel pins: resolves each pin and times pulses on pin 1.
// Assumes registered pin levels on core_clk; an undriven pin reads low.
`timescale 1ns/100ps

module pwm_load (
    // Clock and pins
    input  wire        core_clk,
    input  wire [3:0]  chan_pin_out,
    input  wire [3:0]  chan_pin_oe,
    // Measurements
    output wire [3:0]  pin_level,
    output reg  [15:0] hi_len,
    output reg  [15:0] rise_gap
);
    reg [15:0] hi_cnt  = 16'h0000;
    reg [15:0] gap_cnt = 16'h0000;
    reg        last    = 1'b0;

    // A released pin falls to its pull-down instead of keeping its last level.
    assign pin_level = chan_pin_out & chan_pin_oe;

    always @(posedge core_clk) begin
        last <= pin_level[1];
        hi_cnt <= pin_level[1] ? hi_cnt + 16'h0001 : 16'h0000;
        gap_cnt <= (pin_level[1] && !last) ? 16'h0001 : gap_cnt + 16'h0001;
        if (!pin_level[1] && last) hi_len <= hi_cnt;
        if (pin_level[1] && !last) rise_gap <= gap_cnt;
    end
endmodule // pwm_load

// ### event_compare_pwm_channels_sva.sv
// Checker for the compare channels, watching only the top-level ports.
// Assumes a single core_clk domain with synchronous srst.
`timescale 1ns/100ps

module event_compare_pwm_channels_sva (
    // Clock and reset
    input wire        core_clk,
    input wire        srst,
    // Register port
    input wire [15:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [15:0] reg_rdata,
    // Timer pins
    input wire        timer_one_ext_clock_pin,
    input wire        timer_one_dir_pin,
    input wire        timer_two_ext_clock_pin,
    input wire        timer_two_dir_pin,
    // Channel pins and events
    input wire [3:0]  chan_pin_out,
    input wire [3:0]  chan_pin_oe,
    input wire [3:0]  chan_event,
    input wire        ad_start
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence quiet_six(b);
        !b [*6];
    endsequence

    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read answer");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 16'h1FB0 |=> reg_rdata == 16'h0000)
        else $error("unmapped read returned data");
    a_event_pulse: assert property ((chan_event & $past(chan_event)) == 4'h0)
        else $error("channel event longer than one cycle");
    a_event_spacing: assert property (chan_event[0] |=> quiet_six(chan_event[0]))
        else $error("two matches within one timer step");
    a_ad_match: assert property (ad_start |-> chan_event != 4'h0)
        else $error("conversion start without a match");
    a_pin_lo_cause: assert property (($changed(chan_pin_out[0]) |-> chan_event[0]) and
        ($changed(chan_pin_out[1]) |-> chan_event[1] || chan_event[0]))
        else $error("pin 0 or 1 changed without a match");
    a_pin_hi_cause: assert property (($changed(chan_pin_out[2]) |-> chan_event[2]) and
        ($changed(chan_pin_out[3]) |-> chan_event[3] || chan_event[2]))
        else $error("pin 2 or 3 changed without a match");
    a_oe_from_write: assert property ($changed(chan_pin_oe) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("pin enable changed without a register write");
    a_reset_clears: assert property ($fell(srst) |-> chan_pin_out == 4'h0 && chan_pin_oe == 4'h0)
        else $error("pins not cleared by reset");
endmodule // event_compare_pwm_channels_sva

// ### tb_top.sv
// Self-checking bench for the compare channels with a pin load model.
// Assumes the design constants header and the load and checker modules.
`timescale 1ns/100ps
`include "event_compare_consts.vh"

module tb_top;
    typedef struct { logic [15:0] a; logic [15:0] d; logic [15:0] x; } reg_row_t;
    typedef struct { logic [15:0] ctl; logic rerun; logic pin; int ev; int ad; } act_row_t;
    reg          core_clk;
    reg          srst;
    reg  [15:0]  reg_addr;
    reg  [15:0]  reg_wdata;
    reg          reg_wr;
    reg          reg_rd;
    reg          t2_clk_pin = 1'b0;
    wire [15:0]  reg_rdata;
    wire [3:0]   chan_pin_out;
    wire [3:0]   chan_pin_oe;
    wire [3:0]   chan_event;
    wire         ad_start;
    wire [3:0]   pin_level;
    wire [15:0]  hi_len;
    wire [15:0]  rise_gap;
    logic [15:0] rv;
    int          num_errors;
    int          num_checks;
    int          ev0;
    int          ads;
    int          cyc;
    int          e0;
    int          a0;
    int          n;
    reg_row_t    reg_rows [6] = '{'{16'h1F60, 16'h0100, 16'h0000}, '{16'h1F64, 16'h0100, 16'h0100},
        '{16'h1F68, 16'h0100, 16'h0000}, '{16'h1F6C, 16'h0100, 16'h0100},
        '{16'h1F9A, 16'h1234, 16'h1234}, '{16'h1FB0, 16'hBEEF, 16'h0000}};
    act_row_t    act_rows [4] = '{'{16'h0064, 1'b0, 1'b1, 1, 1}, '{16'h0050, 1'b0, 1'b0, 1, 0},
        '{16'h0070, 1'b1, 1'b1, 1, 0}, '{16'h0078, 1'b1, 1'b1, 2, 0}};

    event_compare_pwm_channels u_event_compare_pwm_channels (
        .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timer_one_ext_clock_pin(1'b0), .timer_one_dir_pin(1'b0),
        .timer_two_ext_clock_pin(t2_clk_pin), .timer_two_dir_pin(1'b1),
        .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe), .chan_event(chan_event),
        .ad_start(ad_start));
    pwm_load u_pwm_load (.core_clk(core_clk), .chan_pin_out(chan_pin_out),
        .chan_pin_oe(chan_pin_oe), .pin_level(pin_level), .hi_len(hi_len), .rise_gap(rise_gap));

    task check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [15:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    // Reloads timer one with zero and waits past an event time of 5.
    task run;
        wr(16'h1F9A, 16'h0000);
        repeat (100) @(posedge core_clk);
    endtask
    task stop_test;
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        #(25 * 20000);
        num_errors++;
        stop_test;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc % 40 == 0) t2_clk_pin <= ~t2_clk_pin;
        if (chan_event[0] === 1'b1) ev0 <= ev0 + 1;
        if (ad_start === 1'b1) ads <= ads + 1;
    end

    initial begin
        srst = 1'b1;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        {num_errors, num_checks} = '0;
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        rd(16'h1F98);
        check(rv, 16'h0000);
        foreach (reg_rows[i]) begin
            wr(reg_rows[i].a, reg_rows[i].d);
            rd(reg_rows[i].a);
            check(rv, reg_rows[i].x);
        end
        wr(16'h1F98, 16'h00C0);
        wr(16'h1F64, 16'h0000);
        wr(16'h1F6C, 16'h0000);
        foreach (act_rows[i]) begin
            e0 = ev0;
            a0 = ads;
            wr(16'h1F60, act_rows[i].ctl);
            wr(16'h1F62, 16'h0005);
            run;
            if (act_rows[i].rerun) run;
            check(pin_level[0], act_rows[i].pin);
            check(16'(ev0 - e0), 16'(act_rows[i].ev));
            check(16'(ads - a0), 16'(act_rows[i].ad));
        end
        // Channel 2 follows timer two only.
        wr(16'h1F68, 16'h00E0);
        wr(16'h1F6A, 16'h0005);
        run;
        check(pin_level[2], 1'b0);
        wr(16'h1F9C, 16'h00C0);
        wr(16'h1F9E, 16'h0000);
        repeat (100) @(posedge core_clk);
        check(pin_level[2], 1'b1);
        wr(16'h1F64, 16'h0040);
        wr(16'h1F9C, 16'h0088);
        repeat (4) @(posedge core_clk);
        check(chan_pin_oe[1:0], 2'b10);
        wr(16'h1F9C, 16'h0090);
        repeat (4) @(posedge core_clk);
        check(chan_pin_oe[1:0], 2'b01);
        wr(16'h1F9C, 16'h0000);
        // One channel sets the shared pin, its partner clears it one count later.
        wr(16'h1F60, 16'h0060);
        wr(16'h1F64, 16'h0150);
        wr(16'h1F62, 16'h0005);
        wr(16'h1F66, 16'h0006);
        run;
        check(chan_pin_oe[1:0], 2'b10);
        check(hi_len, 16'(`TICK_CYC));
        wr(16'h1F60, 16'h0078);
        wr(16'h1F64, 16'h0179);
        wr(16'h1F62, 16'h0003);
        wr(16'h1F66, 16'h0007);
        run;
        repeat (200) @(posedge core_clk);
        check(rise_gap, 16'(7 * `TICK_CYC));
        wr(16'h1F64, 16'h0000);
        wr(16'h1F60, 16'h0070);
        wr(16'h1F9A, 16'h0000);
        wr(16'h1F62, 16'h0005);
        wr(16'h1FA4, 16'h0008);
        wr(16'h1FA2, 16'h0001);
        for (n = 0; n < 200 && chan_event[0] !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        check(16'(n < 200), 16'h0001);
        repeat (`SVC_CYC - 2) @(posedge core_clk);
        rd(16'h1F62);
        check(rv, 16'h0005);
        rd(16'h1F62);
        check(rv, 16'h000D);
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        #1 check({chan_pin_out, chan_pin_oe}, 8'h00);
        rd(16'h1F62);
        check(rv, 16'h0000);
        stop_test;
    end
endmodule // tb_top

bind event_compare_pwm_channels event_compare_pwm_channels_sva u_sva (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_one_ext_clock_pin(timer_one_ext_clock_pin), .timer_one_dir_pin(timer_one_dir_pin),
    .timer_two_ext_clock_pin(timer_two_ext_clock_pin), .timer_two_dir_pin(timer_two_dir_pin),
    .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe), .chan_event(chan_event),
    .ad_start(ad_start));
